//--- hw/cbsl_pkg.sv
`default_nettype none
package cbsl_pkg;
   // error counter limits
   localparam logic [8:0] CBSL_WARN_LIMIT    = 9'h060;  // 96
   localparam logic [8:0] CBSL_PASSIVE_LIMIT = 9'h07F;  // 127
   localparam logic [8:0] CBSL_BUSOFF_LIMIT  = 9'h0FF;  // 255
   localparam logic [8:0] CBSL_CNT_MAX       = 9'h1FF;
   // transmit buffer geometry
   localparam int CBSL_TX_BUFS    = 3;
   localparam int CBSL_TX_BYTES   = 14;
   localparam int CBSL_DATA_BYTES = 8;
   localparam int CBSL_ID_BYTES   = 5;
   // bit timing limits
   localparam int CBSL_PRESC_MIN  = 1;
   localparam int CBSL_PRESC_MAX  = 64;
   localparam int CBSL_TQ_MIN     = 8;
   localparam int CBSL_TQ_MAX     = 25;
   localparam int CBSL_ID_BITS    = 29;
   // transmit engine states
   typedef enum logic [2:0] {
      CBSL_IDLE = 3'h1,
      CBSL_SEND = 3'h2,
      CBSL_DONE = 3'h4
   } cbsl_tx_state_t;
endpackage : cbsl_pkg
`default_nettype wire

//--- hw/cbsl_core.sv
// Functional notes
// R1: two acceptance masks, zero bit always matches
// R2: overrun sets buffer overrun and error flags
// R3: no double buffering: buffer zero never diverts
// R4: double buffering: divert to one, else overrun
// R5: receive errors bump receive error count
// R6: receive count at 96 sets warning flag
// R7: loaded message flags its buffer interrupt
// R8: wake-up raises wake-up interrupt
// R9: receive error sets invalid-message and error flags
// R10: receive count above 127 gives error-passive
// R11: three transmit buffers of fourteen bytes
// R12: two-bit priority, 11 highest, 00 lowest
// R13: request write clears aborted, lost, error flags
// R14: highest priority queued buffer sent first
// R15: first-attempt success clears request, interrupts
// R16: failure keeps request, sets error or lost
// R17: aborts honoured when idle, set aborted flag
// R18: transmit errors count, above 96 warn
// R19: above 127 passive, above 255 bus-off
// R20: empty transmit buffer raises transmit interrupt
// R21: bit time is 8 to 25 quanta
// R22: quantum from prescaler 1..64 then divide by two
`timescale 1ns/1ps
`default_nettype none
module cbsl_core
   import cbsl_pkg::*;
#(
   parameter int ID_W = CBSL_ID_BITS
) (
   // clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst,
   // acceptance masks and filters, one per receive buffer
   input  wire logic [ID_W-1:0]      rx_mask0,
   input  wire logic [ID_W-1:0]      rx_mask1,
   input  wire logic [ID_W-1:0]      rx_filter0,
   input  wire logic [ID_W-1:0]      rx_filter1,
   input  wire logic                 double_buffer_enable,
   // message assembly buffer hand-off from the protocol engine
   input  wire logic                 frame_valid,
   input  wire logic [ID_W-1:0]      frame_id,
   input  wire logic                 rx_crc_error,
   input  wire logic                 rx_stuff_error,
   input  wire logic                 rx_invalid_error,
   // software release of receive buffers and flag clears
   input  wire logic [1:0]           rx_release,
   input  wire logic [1:0]           rx_if_clear,
   input  wire logic [1:0]           rx_ovr_clear,
   input  wire logic                 error_flag_clear,
   input  wire logic                 invalid_clear,
   input  wire logic                 wake_event,
   input  wire logic                 wake_clear,
   // transmit control
   input  wire logic [2:0]           tx_request_set,
   input  wire logic [2:0]           tx_request_clear,
   input  wire logic [5:0]           tx_priority_field,
   input  wire logic                 abort_all_pending,
   input  wire logic                 tx_interrupt_enable,
   input  wire logic [2:0]           tx_if_clear,
   // bus engine status
   input  wire logic                 bus_available,
   input  wire logic                 tx_success,
   input  wire logic                 tx_arb_lost,
   input  wire logic                 tx_ack_error,
   input  wire logic                 tx_form_error,
   input  wire logic                 tx_bit_error,
   // bit timing
   input  wire logic [5:0]           baud_prescale,
   input  wire logic [4:0]           bit_quanta,
   // receive status
   output logic [1:0]                rx_buffer_full,
   output logic [1:0]                rx_buffer_interrupt_flag,
   output logic [1:0]                rx_buffer_overrun_flag,
   output logic                      error_interrupt_flag,
   output logic                      invalid_message_flag,
   output logic                      rx_warning_flag,
   output logic                      rx_error_passive_flag,
   output logic [7:0]                receive_error_count,
   output logic                      wake_interrupt_flag,
   // transmit status
   output logic [2:0]                tx_request_bit,
   output logic [2:0]                tx_aborted_flag,
   output logic [2:0]                tx_arbitration_lost_flag,
   output logic [2:0]                tx_error_flag,
   output logic [2:0]                tx_buffer_interrupt_flag,
   output logic                      tx_warning_flag,
   output logic                      tx_error_passive_flag,
   output logic                      bus_off_flag,
   output logic [7:0]                transmit_error_count,
   output logic                      tx_active,
   output logic [1:0]                tx_active_buf,
   // bit timing strobes
   output logic                      tq_tick,
   output logic                      bit_tick
);

   if (ID_W < 1 || ID_W > CBSL_ID_BITS) $error("cbsl_core: bad ID_W"); // refuse bad widths

   // acceptance decision, zero mask bit is a don't care
   logic       hit0, hit1, rx_err;
   assign hit0   = (((frame_id ^ rx_filter0) & rx_mask0) == '0); // [R1]
   assign hit1   = (((frame_id ^ rx_filter1) & rx_mask1) == '0); // [R1]
   assign rx_err = rx_crc_error | rx_stuff_error | rx_invalid_error;

   // routing of an accepted, clean message
   logic [1:0] load, ovr;
   always_comb begin
      load = 2'h0;
      ovr  = 2'h0;
      if (frame_valid && !rx_err) begin
         if (hit0) begin
            if (!rx_buffer_full[0]) begin
               load[0] = 1'b1;
            end else if (double_buffer_enable && !rx_buffer_full[1]) begin
               load[1] = 1'b1; // [R4]
            end else if (double_buffer_enable) begin
               ovr[1] = 1'b1; // [R4]
            end else begin
               ovr[0] = 1'b1; // [R3]
            end
         end else if (hit1) begin
            if (!rx_buffer_full[1]) load[1] = 1'b1;
            else ovr[1] = 1'b1; // [R2]
         end
      end
   end

   // receive buffer occupancy and per-buffer flags, set wins over clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_buffer_full           <= 2'h0;
         rx_buffer_interrupt_flag <= 2'h0;
         rx_buffer_overrun_flag   <= 2'h0;
      end else begin
         rx_buffer_full           <= (rx_buffer_full & ~rx_release) | load;
         rx_buffer_interrupt_flag <= (rx_buffer_interrupt_flag & ~rx_if_clear) | load; // [R7]
         rx_buffer_overrun_flag   <= (rx_buffer_overrun_flag & ~rx_ovr_clear) | ovr; // [R2]
      end
   end

   // receive error counter, saturating
   logic [8:0] next_rec;
   assign next_rec = {1'b0, receive_error_count} + 9'h001;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         receive_error_count <= 8'h00;
      end else if (frame_valid && rx_err && receive_error_count != 8'hFF) begin
         receive_error_count <= next_rec[7:0]; // [R5]
      end
   end

   // transmit error counter, one extra bit to see the bus-off crossing
   logic [8:0] tec;
   logic       tx_err_ev;
   assign tx_err_ev = tx_active && (tx_ack_error | tx_form_error | tx_bit_error);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tec <= 9'h000;
      end else if (tx_err_ev && tec != CBSL_CNT_MAX) begin
         tec <= tec + 9'h001; // [R18]
      end
   end

   // error state flags derived from the counters
   logic rx_warn_now, tx_warn_now;
   assign rx_warn_now = {1'b0, receive_error_count} >= CBSL_WARN_LIMIT;
   assign tx_warn_now = tec > CBSL_WARN_LIMIT;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_warning_flag       <= 1'b0;
         rx_error_passive_flag <= 1'b0;
         tx_warning_flag       <= 1'b0;
         tx_error_passive_flag <= 1'b0;
         bus_off_flag          <= 1'b0;
         transmit_error_count  <= 8'h00;
      end else begin
         rx_warning_flag       <= rx_warn_now; // [R6]
         rx_error_passive_flag <= {1'b0, receive_error_count} > CBSL_PASSIVE_LIMIT; // [R10]
         tx_warning_flag       <= tx_warn_now; // [R18]
         tx_error_passive_flag <= tec > CBSL_PASSIVE_LIMIT; // [R19]
         bus_off_flag          <= bus_off_flag | (tec > CBSL_BUSOFF_LIMIT); // [R19]
         transmit_error_count  <= tec[8] ? 8'hFF : tec[7:0];
      end
   end

   // common error and invalid-message flags, set wins over clear
   logic err_set;
   assign err_set = (|ovr) | (frame_valid && rx_err) | (rx_warn_now && !rx_warning_flag)
                  | (tx_warn_now && !tx_warning_flag) | (tx_err_ev && tx_interrupt_enable);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         error_interrupt_flag <= 1'b0;
         invalid_message_flag <= 1'b0;
         wake_interrupt_flag  <= 1'b0;
      end else begin
         error_interrupt_flag <= (error_interrupt_flag & ~error_flag_clear) | err_set; // [R2] [R9]
         invalid_message_flag <= (invalid_message_flag & ~invalid_clear)
                               | (frame_valid & rx_err); // [R9]
         wake_interrupt_flag  <= (wake_interrupt_flag & ~wake_clear) | wake_event; // [R8]
      end
   end

   // highest priority pending buffer, lower index wins a tie
   logic [1:0] best;
   logic       any_pend;
   always_comb begin
      best     = 2'h0;
      any_pend = 1'b0;
      for (int i = CBSL_TX_BUFS - 1; i >= 0; i--) begin
         if (tx_request_bit[i] && (!any_pend ||
             tx_priority_field[2*i +: 2] >= tx_priority_field[2*best +: 2])) begin
            best     = 2'(i); // [R12] [R14]
            any_pend = 1'b1;
         end
      end
   end

   // transmit engine; priority is sampled only at start of frame
   cbsl_tx_state_t state;
   logic           end_ev;
   assign end_ev = tx_success | tx_arb_lost | tx_err_ev;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state         <= CBSL_IDLE;
         tx_active     <= 1'b0;
         tx_active_buf <= 2'h0;
      end else begin
         case (state)
            CBSL_IDLE: begin
               if (bus_available && any_pend && !bus_off_flag && !abort_all_pending) begin
                  state         <= CBSL_SEND;
                  tx_active     <= 1'b1;
                  tx_active_buf <= best; // [R14]
               end
            end
            CBSL_SEND: begin
               if (end_ev) begin
                  state     <= CBSL_DONE;
                  tx_active <= 1'b0;
               end
            end
            CBSL_DONE: state <= CBSL_IDLE;
            default:   state <= CBSL_IDLE;
         endcase
      end
   end

   // per-buffer request and outcome flags
   genvar g;
   generate
      for (g = 0; g < CBSL_TX_BUFS; g++) begin : g_txb // [R11]
         logic mine, abort_req;
         assign mine      = tx_active && tx_active_buf == 2'(g);
         assign abort_req = (tx_request_clear[g] | abort_all_pending) & tx_request_bit[g];
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               tx_request_bit[g]           <= 1'b0;
               tx_aborted_flag[g]          <= 1'b0;
               tx_arbitration_lost_flag[g] <= 1'b0;
               tx_error_flag[g]            <= 1'b0;
            end else if (tx_request_set[g]) begin
               tx_request_bit[g]           <= 1'b1;
               tx_aborted_flag[g]          <= 1'b0; // [R13]
               tx_arbitration_lost_flag[g] <= 1'b0; // [R13]
               tx_error_flag[g]            <= 1'b0; // [R13]
            end else if (mine && tx_success) begin
               tx_request_bit[g] <= 1'b0; // [R15]
            end else if (mine && tx_arb_lost) begin
               tx_arbitration_lost_flag[g] <= 1'b1; // [R16]
               if (abort_req) begin
                  tx_request_bit[g]  <= 1'b0;
                  tx_aborted_flag[g] <= 1'b1; // [R17]
               end
            end else if (mine && tx_err_ev) begin
               tx_error_flag[g] <= 1'b1; // [R16]
               if (abort_req) begin
                  tx_request_bit[g]  <= 1'b0;
                  tx_aborted_flag[g] <= 1'b1; // [R17]
               end
            end else if (abort_req && !mine) begin
               tx_request_bit[g]  <= 1'b0;
               tx_aborted_flag[g] <= 1'b1; // [R17]
            end
         end
         // buffer available interrupt, only after a successful send
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               tx_buffer_interrupt_flag[g] <= 1'b0;
            end else begin
               tx_buffer_interrupt_flag[g] <= (tx_buffer_interrupt_flag[g] & ~tx_if_clear[g])
                  | (mine & tx_success & tx_interrupt_enable); // [R15] [R20]
            end
         end
      end
   endgenerate

   // quantum: prescaler (value+1) then divide by two
   logic [5:0] pre_cnt;
   logic       half;
   logic [4:0] q_cnt, quanta;
   assign quanta = (bit_quanta < 5'(CBSL_TQ_MIN)) ? 5'(CBSL_TQ_MIN) :
                   (bit_quanta > 5'(CBSL_TQ_MAX)) ? 5'(CBSL_TQ_MAX) : bit_quanta; // [R21]
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pre_cnt <= 6'h00;
         half    <= 1'b0;
         tq_tick <= 1'b0;
      end else begin
         tq_tick <= 1'b0;
         if (pre_cnt >= baud_prescale) begin
            pre_cnt <= 6'h00;
            half    <= ~half;
            tq_tick <= half; // [R22]
         end else begin
            pre_cnt <= pre_cnt + 6'h01; // [R22]
         end
      end
   end

   // quanta per bit counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q_cnt    <= 5'h00;
         bit_tick <= 1'b0;
      end else begin
         bit_tick <= 1'b0;
         if (tq_tick) begin
            if (q_cnt >= quanta - 5'h01) begin
               q_cnt    <= 5'h00;
               bit_tick <= 1'b1; // [R21]
            end else begin
               q_cnt <= q_cnt + 5'h01;
            end
         end
      end
   end

   // checks
   overrun_err_a: assert property (@(posedge clk) disable iff (rst) // [R2]
      (|ovr) |=> error_interrupt_flag) else $error("overrun without error flag");
   no_divert_a: assert property (@(posedge clk) disable iff (rst) // [R3]
      (!double_buffer_enable && ovr[0] && !rx_buffer_full[1])
      |=> !rx_buffer_full[1] && rx_buffer_overrun_flag[0]) else $error("diverted");
   dbl_divert_a: assert property (@(posedge clk) disable iff (rst) // [R4]
      (double_buffer_enable && hit0 && frame_valid && !rx_err && rx_buffer_full == 2'h1)
      |=> rx_buffer_full[1]) else $error("no divert");
   rec_inc_a: assert property (@(posedge clk) disable iff (rst) // [R5]
      (frame_valid && rx_err && receive_error_count < 8'hFF)
      |=> receive_error_count == $past(receive_error_count) + 8'h01) else $error("rec");
   rx_warn_a: assert property (@(posedge clk) disable iff (rst) // [R6]
      (receive_error_count >= 8'h60) |=> rx_warning_flag) else $error("rx warn");
   rx_load_if_a: assert property (@(posedge clk) disable iff (rst) // [R7]
      load[0] |=> rx_buffer_interrupt_flag[0]) else $error("rx flag");
   req_clr_a: assert property (@(posedge clk) disable iff (rst) // [R13]
      tx_request_set[0] |=> tx_request_bit[0] && !tx_aborted_flag[0] && !tx_error_flag[0])
      else $error("request");
   success_a: assert property (@(posedge clk) disable iff (rst) // [R15]
      (tx_active && tx_success && !tx_request_set[tx_active_buf])
      |=> !tx_request_bit[$past(tx_active_buf)]) else $error("success");
   lost_keep_a: assert property (@(posedge clk) disable iff (rst) // [R16]
      (tx_active && tx_arb_lost && !tx_request_clear[tx_active_buf] && !abort_all_pending)
      |=> tx_request_bit[$past(tx_active_buf)]) else $error("lost");
   busoff_a: assert property (@(posedge clk) disable iff (rst) // [R19]
      (tec > 9'h0FF) |=> bus_off_flag) else $error("bus off");
   tq_gap_a: assert property (@(posedge clk) disable iff (rst) // [R22]
      (tq_tick && baud_prescale == 6'h00 && $stable(baud_prescale)) |=> !tq_tick)
      else $error("tq");
endmodule : cbsl_core
`default_nettype wire

//--- bench/cbsl_bus_node.sv
`timescale 1ns/1ps
`default_nettype none
// other nodes on the bus: free the bus on grant and end each attempt
module cbsl_bus_node (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // bench control: outcome 0 ok, 1 lost, 2 ack, 3 form, 4 bit error
   input  wire logic       grant,
   input  wire logic [2:0] outcome,
   input  wire logic [3:0] delay_cyc,
   // link to the controller
   input  wire logic       tx_active,
   output logic            bus_available,
   output logic            tx_success,
   output logic            tx_arb_lost,
   output logic            tx_ack_error,
   output logic            tx_form_error,
   output logic            tx_bit_error
);
   logic       armed;
   logic       busy;
   logic [3:0] cnt;
   // bus idle only while the bench grants it
   assign bus_available = grant;
   // one end pulse per attempt, prompt or slow as the delay says
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         armed         <= 1'b1;
         busy          <= 1'b0;
         cnt           <= 4'h0;
         tx_success    <= 1'b0;
         tx_arb_lost   <= 1'b0;
         tx_ack_error  <= 1'b0;
         tx_form_error <= 1'b0;
         tx_bit_error  <= 1'b0;
      end else begin
         tx_success    <= 1'b0;
         tx_arb_lost   <= 1'b0;
         tx_ack_error  <= 1'b0;
         tx_form_error <= 1'b0;
         tx_bit_error  <= 1'b0;
         if (!tx_active) begin
            armed <= 1'b1;
         end else if (armed) begin
            armed <= 1'b0;
            busy  <= 1'b1;
            cnt   <= delay_cyc;
         end else if (busy && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
         end else if (busy) begin
            busy          <= 1'b0;
            tx_success    <= (outcome == 3'h0);
            tx_arb_lost   <= (outcome == 3'h1);
            tx_ack_error  <= (outcome == 3'h2);
            tx_form_error <= (outcome == 3'h3);
            tx_bit_error  <= (outcome == 3'h4);
         end
      end
   end
endmodule : cbsl_bus_node
`default_nettype wire

//--- bench/cbsl_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cbsl_core_tb;
   logic        clk, rst, grant, double_buffer_enable, frame_valid, rx_crc_error, rx_stuff_error;
   logic        rx_invalid_error, error_flag_clear, invalid_clear, wake_event, wake_clear;
   logic        abort_all_pending, tx_interrupt_enable, bus_available, tx_success, tx_arb_lost;
   logic        tx_ack_error, tx_form_error, tx_bit_error, error_interrupt_flag;
   logic        invalid_message_flag, rx_warning_flag, rx_error_passive_flag, wake_interrupt_flag;
   logic        tx_warning_flag, tx_error_passive_flag, bus_off_flag, tx_active, tq_tick, bit_tick;
   logic [28:0] rx_mask0, rx_mask1, rx_filter0, rx_filter1, frame_id;
   logic [1:0]  rx_release, rx_if_clear, rx_ovr_clear, rx_buffer_full, tx_active_buf;
   logic [1:0]  rx_buffer_interrupt_flag, rx_buffer_overrun_flag;
   logic [2:0]  tx_request_set, tx_request_clear, tx_if_clear, tx_request_bit, tx_aborted_flag;
   logic [2:0]  tx_arbitration_lost_flag, tx_error_flag, tx_buffer_interrupt_flag, outcome;
   logic [5:0]  tx_priority_field, baud_prescale;
   logic [4:0]  bit_quanta;
   logic [7:0]  receive_error_count, transmit_error_count;
   logic [3:0]  delay_cyc;
   int          failures, n_tests, cycles;

   cbsl_core DUT (.*);
   cbsl_bus_node node (.*);

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: saw %0h expected %0h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done;
      $display("tests %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         test_done();
      end
   end

   // one assembled frame, e: 0 clean, 1 checksum, 2 stuffing, 3 invalid
   task automatic rx(input logic [28:0] id, input int e);
      frame_valid = 1'b1;
      frame_id = id;
      rx_crc_error = (e == 1);
      rx_stuff_error = (e == 2);
      rx_invalid_error = (e == 3);
      cyc(1);
      {frame_valid, rx_crc_error, rx_stuff_error, rx_invalid_error} = 4'h0;
      cyc(1);
   endtask : rx

   task automatic rx_free;
      {rx_release, rx_ovr_clear, rx_if_clear, error_flag_clear, invalid_clear} = 8'hFF;
      cyc(1);
      {rx_release, rx_ovr_clear, rx_if_clear, error_flag_clear, invalid_clear} = 8'h00;
      cyc(1);
   endtask : rx_free

   task automatic rx_routing;
      rx_mask0 = 29'h1FFFFFFE;
      rx_filter0 = 29'h122;
      rx_mask1 = 29'h1FFFFFFF;
      rx_filter1 = 29'h456;
      rx(29'h123, 0);
      chk({rx_buffer_full, rx_buffer_interrupt_flag}, 4'h5);
      rx(29'h123, 0);
      chk({rx_buffer_overrun_flag, error_interrupt_flag, rx_buffer_full}, 5'h0D);
      rx(29'h456, 0);
      chk({rx_buffer_full, rx_buffer_interrupt_flag}, 4'hF);
      rx_free();
      double_buffer_enable = 1'b1;
      rx(29'h123, 0);
      rx(29'h123, 0);
      chk({rx_buffer_full, rx_buffer_overrun_flag}, 4'hC);
      rx(29'h123, 0);
      chk({rx_buffer_overrun_flag, error_interrupt_flag}, 3'h5);
      rx_free();
   endtask : rx_routing

   task automatic rx_errors;
      for (int i = 0; i < 128; i++) begin
         rx(29'h123, 1 + i % 3);
         if (i == 0) chk({invalid_message_flag, error_interrupt_flag, rx_buffer_full}, 4'hC);
         chk(receive_error_count, i + 1);
         if (i == 94 || i == 95) chk(rx_warning_flag, i == 95);
         if (i == 126 || i == 127) chk(rx_error_passive_flag, i == 127);
      end
      wake_event = 1'b1;
      cyc(1);
      wake_event = 1'b0;
      cyc(1);
      chk(wake_interrupt_flag, 1'b1);
   endtask : rx_errors

   // one attempt on the bus with the given ending
   task automatic attempt(input logic [2:0] code, input logic [1:0] exp_buf);
      int k;
      k = 0;
      outcome = code;
      grant = 1'b1;
      while (tx_active !== 1'b1 && k < 50) begin
         cyc(1);
         k++;
      end
      grant = 1'b0;
      chk(tx_active_buf, exp_buf);
      k = 0;
      while (tx_active !== 1'b0 && k < 50) begin
         cyc(1);
         k++;
      end
      cyc(2);
   endtask : attempt

   task automatic tx_sequence;
      tx_interrupt_enable = 1'b1;
      tx_priority_field = 6'h2D;
      tx_request_set = 3'h7;
      cyc(1);
      tx_request_set = 3'h0;
      cyc(1);
      attempt(3'h1, 2'h1);
      chk({tx_request_bit, tx_arbitration_lost_flag, tx_buffer_interrupt_flag}, 9'h1D0);
      tx_priority_field = 6'h31;
      delay_cyc = 4'h6;
      attempt(3'h0, 2'h2);
      chk({tx_request_bit, tx_buffer_interrupt_flag}, 6'h1C);
      tx_request_set = 3'h2;
      cyc(1);
      tx_request_set = 3'h0;
      cyc(1);
      chk(tx_arbitration_lost_flag, 3'h0);
      tx_request_clear = 3'h2;
      cyc(1);
      tx_request_clear = 3'h0;
      cyc(1);
      chk({tx_request_bit, tx_aborted_flag, tx_buffer_interrupt_flag}, 9'h054);
      abort_all_pending = 1'b1;
      cyc(1);
      abort_all_pending = 1'b0;
      cyc(1);
      chk({tx_request_bit, tx_aborted_flag}, 6'h03);
      tx_request_set = 3'h1;
      cyc(1);
      tx_request_set = 3'h0;
      cyc(1);
      for (int c = 2; c <= 4; c++) begin
         attempt(c[2:0], 2'h0);
         chk({transmit_error_count, tx_error_flag, tx_request_bit}, {c[7:0] - 8'h1, 6'h09});
      end
      tx_request_set = 3'h1;
      cyc(1);
      tx_request_set = 3'h0;
      cyc(1);
      chk({tx_error_flag, tx_aborted_flag}, 6'h02);
   endtask : tx_sequence

   task automatic wt(input logic [7:0] v);
      int k;
      k = 0;
      while (transmit_error_count !== v && k < 3000) begin
         cyc(1);
         k++;
      end
      cyc(1);
   endtask : wt

   task automatic tx_counting;
      // errors with the enable set also raise the error flag; keep only the warning crossing
      tx_interrupt_enable = 1'b0;
      error_flag_clear = 1'b1;
      cyc(1);
      error_flag_clear = 1'b0;
      outcome = 3'h2;
      grant = 1'b1;
      wt(8'd96);
      chk({tx_warning_flag, error_interrupt_flag}, 2'h0);
      wt(8'd97);
      chk({tx_warning_flag, error_interrupt_flag}, 2'h3);
      wt(8'd127);
      chk(tx_error_passive_flag, 1'b0);
      wt(8'd128);
      chk(tx_error_passive_flag, 1'b1);
      for (int k = 0; k < 3000 && bus_off_flag !== 1'b1; k++) cyc(1);
      chk({bus_off_flag, transmit_error_count}, 9'h1FF);
      cyc(20);
      chk(tx_active, 1'b0);
   endtask : tx_counting

   // tick spacing over four bit times
   task automatic timing(input logic [5:0] p, input logic [4:0] q, input int tqp, input int bp);
      int nt, nb;
      nt = 0;
      nb = 0;
      baud_prescale = p;
      bit_quanta = q;
      cyc(2 * bp);
      for (int k = 0; k < bp + 2 && bit_tick !== 1'b1; k++) cyc(1);
      for (int k = 0; k < 4 * bp; k++) begin
         cyc(1);
         nt += (tq_tick === 1'b1);
         nb += (bit_tick === 1'b1);
      end
      chk(nt, 4 * bp / tqp);
      chk(nb, 4);
   endtask : timing

   initial begin
      {rst, grant, double_buffer_enable, frame_valid, rx_crc_error, rx_stuff_error} = 6'h20;
      {rx_invalid_error, error_flag_clear, invalid_clear, wake_event, wake_clear} = 5'h0;
      {abort_all_pending, tx_interrupt_enable, rx_release, rx_if_clear, rx_ovr_clear} = 8'h0;
      {rx_mask0, rx_mask1, rx_filter0, rx_filter1, frame_id} = '0;
      {tx_request_set, tx_request_clear, tx_if_clear, outcome, delay_cyc} = '0;
      {tx_priority_field, baud_prescale, bit_quanta} = '0;
      {failures, n_tests, cycles} = '0;
      cyc(16);
      rst = 1'b0;
      cyc(1);
      rx_routing();
      rx_errors();
      timing(6'd1, 5'd10, 4, 40);
      timing(6'd0, 5'd5, 2, 16);
      timing(6'd63, 5'd25, 128, 3200);
      tx_sequence();
      tx_counting();
      test_done();
   end
endmodule : cbsl_core_tb
`default_nettype wire
